// File: logic/pin_cfg_pkg.sv
// Constants, field positions and loader states for the pin function setup.
package pin_cfg_pkg;

  // Hardware configuration area of the flash information page.
  localparam int INFO_AW = 10;
  localparam logic [9:0] FLAG_OFS = 10'h000;
  localparam logic [9:0] PIN_A_OFS = 10'h001;
  localparam logic [9:0] PIN_B_OFS = 10'h002;
  localparam logic [9:0] PIN_C_OFS = 10'h003;
  localparam logic [9:0] USB_PULL_OFS = 10'h004;
  localparam int CFG_BYTES = 4;

  // Marker that says the stored settings are valid.
  localparam logic [7:0] FLAG_VALID = 8'ha6;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // Bits 7:4 of the third setting byte are reserved and read as zero.
  localparam logic [7:0] PIN_C_USED = 8'h0f;

  // First setting byte: only these two bits steer this block.
  localparam int A_P0_HI = 2;
  localparam int A_P17 = 7;

  // Second setting byte.
  localparam int B_P20 = 0;
  localparam int B_DBG = 1;
  localparam int B_MODEM_A = 2;
  localparam int B_MODEM_B = 3;
  localparam int B_SPI_TGT = 4;
  localparam int B_KBD = 5;
  localparam int B_I2C0 = 6;
  localparam int B_I2C1 = 7;

  // Third setting byte.
  localparam int C_DS0 = 0;
  localparam int C_DS1 = 1;
  localparam int C_BUZZER = 2;
  localparam int C_SWAP = 3;

  // USB resistor byte: upstream nibble low, downstream nibble high.
  localparam int PULL_UP_LSB = 0;
  localparam int PULL_DN_LSB = 4;

  // Level seen by a function whose pin is not routed to it.
  localparam logic IDLE_IN = 1'b1;
  // SPI master group {miso, mosi, clk, select}: only miso is an input.
  localparam logic [3:0] MST_GRP_OEN = 4'h8;

  typedef enum logic [2:0] {
    LD_START = 3'b000,
    LD_ASK = 3'b001,
    LD_WAIT = 3'b010,
    LD_DONE = 3'b011,
    LD_BLOCK = 3'b100
  } ld_state_t;

endpackage

// File: logic/cfg_page_loader.sv
// Power-on loader that copies the hardware configuration bytes from flash.
`timescale 1ns/10ps
module cfg_page_loader (
  input logic mclk,
  input logic resetn,
  output logic infoRead,
  output logic [pin_cfg_pkg::INFO_AW-1:0] infoAddr,
  input logic [7:0] infoData,
  input logic infoValid,
  output logic loadDone,
  output logic loadOk,
  output logic [7:0] selA,
  output logic [7:0] selB,
  output logic [7:0] selC,
  output logic [7:0] usbPull
);
  import pin_cfg_pkg::*;

  ld_state_t state_q, state_d;
  logic [INFO_AW-1:0] addr_q, addr_d;
  logic [7:0] shadow_q [CFG_BYTES];
  logic loadDone_q, loadOk_q;
  logic [7:0] selA_q, selB_q, selC_q, pull_q;

  wire isFlag = addr_q == FLAG_OFS;
  wire lastByte = addr_q == USB_PULL_OFS;
  wire flagGood = infoData == FLAG_VALID;
  wire [INFO_AW-1:0] slotFull = addr_q - PIN_A_OFS;
  wire [1:0] slot = slotFull[1:0];
  wire takeByte = state_q == LD_WAIT && infoValid && !isFlag;
  // Bytes are copied out together one cycle after the last arrives.
  wire commit = state_q == LD_DONE && !loadDone_q;

  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    case (state_q)
      LD_START: begin
        state_d = LD_ASK;
        addr_d = FLAG_OFS;
      end
      LD_ASK: state_d = LD_WAIT;
      LD_WAIT: begin
        if (infoValid && isFlag) begin
          if (flagGood) begin
            state_d = LD_ASK;
            addr_d = PIN_A_OFS;
          end else begin
            state_d = LD_BLOCK;
          end
        end else if (infoValid && lastByte) begin
          state_d = LD_DONE;
        end else if (infoValid) begin
          state_d = LD_ASK;
          addr_d = addr_q + 10'h001;
        end
      end
      LD_DONE: state_d = LD_DONE;
      LD_BLOCK: state_d = LD_BLOCK;
      default: state_d = LD_START;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_q <= LD_START;
      addr_q <= FLAG_OFS;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (takeByte) begin
      shadow_q[slot] <= infoData;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      loadDone_q <= 1'b0;
      loadOk_q <= 1'b0;
      selA_q <= CFG_RESET;
      selB_q <= CFG_RESET;
      selC_q <= CFG_RESET;
      pull_q <= CFG_RESET;
    end else if (commit) begin
      loadDone_q <= 1'b1;
      loadOk_q <= 1'b1;
      selA_q <= shadow_q[0];
      selB_q <= shadow_q[1];
      selC_q <= shadow_q[2] & PIN_C_USED;
      pull_q <= shadow_q[3];
    end else if (state_q == LD_BLOCK) begin
      loadDone_q <= 1'b1;
    end
  end

  assign infoRead = state_q == LD_ASK;
  assign infoAddr = addr_q;
  assign loadDone = loadDone_q;
  assign loadOk = loadOk_q;
  assign selA = selA_q;
  assign selB = selB_q;
  assign selC = selC_q;
  assign usbPull = pull_q;

endmodule // cfg_page_loader

// File: logic/multifunction_pin_select_cfg.sv
// Shared pin multiplexer steered by configuration loaded from flash.
`timescale 1ns/10ps
module multifunction_pin_select_cfg (
  input logic mclk,
  input logic resetn,
  output logic infoRead,
  output logic [pin_cfg_pkg::INFO_AW-1:0] infoAddr,
  input logic [7:0] infoData,
  input logic infoValid,
  output logic loaderDone,
  output logic pinsBlocked,
  output logic [7:0] pinFunctionSelectA,
  output logic [7:0] pinFunctionSelectB,
  output logic [7:0] pinFunctionSelectC,
  output logic [7:0] usbResistorDisable,
  input logic [7:0] gpio0Out,
  input logic [7:0] gpio0OeN,
  output logic [7:0] gpio0In,
  input logic gpio1Bit7Out,
  input logic gpio1Bit7OeN,
  output logic gpio1Bit7In,
  input logic [7:0] gpio2Out,
  input logic [7:0] gpio2OeN,
  output logic [7:0] gpio2In,
  input logic [7:0] gpio3Out,
  input logic [7:0] gpio3OeN,
  output logic [7:0] gpio3In,
  output logic debuggerDataIn,
  input logic debuggerClockOut,
  input logic debuggerDataOut,
  output logic modemClearToSend,
  output logic modemDataSetReady,
  output logic modemRing,
  output logic modemCarrier,
  input logic mstSel0N,
  input logic mstSel1N,
  input logic mstSel2N,
  input logic mstClk,
  input logic mstMosi,
  output logic mstMiso,
  output logic tgtSelN,
  output logic tgtClk,
  output logic tgtMosi,
  input logic tgtMiso,
  input logic tgtMisoOeN,
  input logic [3:0] kbdMouseOeN,
  output logic [3:0] kbdMouseIn,
  input logic [3:0] i2cTargetOeN,
  output logic [3:0] i2cTargetIn,
  input logic [1:0] downstreamPowerEnable,
  output logic [1:0] downstreamOvercurrent,
  input logic [3:0] p0HiPadIn,
  output logic [3:0] p0HiPadOut,
  output logic [3:0] p0HiPadOeN,
  input logic p17PadIn,
  output logic p17PadOut,
  output logic p17PadOeN,
  input logic [7:0] p2PadIn,
  output logic [7:0] p2PadOut,
  output logic [7:0] p2PadOeN,
  input logic [7:0] p3PadIn,
  output logic [7:0] p3PadOut,
  output logic [7:0] p3PadOeN,
  input logic [3:0] i2cPadIn,
  output logic [3:0] i2cPadOut,
  output logic [3:0] i2cPadOeN,
  input logic [3:0] usbPwrPadIn,
  output logic [3:0] usbPwrPadOut,
  output logic [3:0] usbPwrPadOeN,
  input logic [3:0] upPullupReq,
  output logic [3:0] upPullupEn,
  output logic [3:0] downPulldownEn
);
  import pin_cfg_pkg::*;

  // Bitwise pick: where a select bit is set, the peripheral side wins.
  function automatic logic [7:0] pick(input logic [7:0] s,
                                      input logic [7:0] gpio,
                                      input logic [7:0] per);
    pick = (s & per) | (~s & gpio);
  endfunction

  logic loadDone, loadOk;
  logic [7:0] selA, selB, selC, usbPull;

  cfg_page_loader loader (
    .mclk(mclk),
    .resetn(resetn),
    .infoRead(infoRead),
    .infoAddr(infoAddr),
    .infoData(infoData),
    .infoValid(infoValid),
    .loadDone(loadDone),
    .loadOk(loadOk),
    .selA(selA),
    .selB(selB),
    .selC(selC),
    .usbPull(usbPull)
  );

  // Until a valid load every pad is released and every pad output held low.
  wire blocked = !loadOk;
  wire [7:0] blockOeN = {8{blocked}};
  wire [7:0] passOut = {8{!blocked}};

  // Select bits from the latched bytes; the two I2C selects also need p0HiSel.
  wire p0HiSel = selA[A_P0_HI];
  wire p17Sel = selA[A_P17];
  wire p20Sel = selB[B_P20];
  wire dbgSel = selB[B_DBG];
  wire modemASel = selB[B_MODEM_A];
  wire modemBSel = selB[B_MODEM_B];
  wire spiTgtSel = selB[B_SPI_TGT];
  wire kbdSel = selB[B_KBD];
  // A port that still owns its pins as GPIO cannot lend them to I2C.
  wire i2c0Sel = selB[B_I2C0] & p0HiSel;
  wire i2c1Sel = selB[B_I2C1] & p0HiSel;
  wire ds0Sel = selC[C_DS0];
  wire ds1Sel = selC[C_DS1];
  wire spiSwap = selC[C_SWAP];

  // SPI groups, ordered {miso, mosi, clk, select}.
  wire [3:0] mstGrpOut = {1'b0, mstMosi, mstClk, mstSel0N};
  wire [3:0] mstGrpOeN = MST_GRP_OEN;
  wire [3:0] tgtGrpOut = {tgtMiso, 3'b000};
  wire [3:0] tgtGrpOeN = {tgtMisoOeN, 3'b111};
  wire [3:0] p0GrpOut = spiSwap ? tgtGrpOut : mstGrpOut;
  wire [3:0] p0GrpOeN = spiSwap ? tgtGrpOeN : mstGrpOeN;
  wire [3:0] p3GrpOut = spiSwap ? mstGrpOut : tgtGrpOut;
  wire [3:0] p3GrpOeN = spiSwap ? mstGrpOeN : tgtGrpOeN;
  // Group input bits, as seen on each nibble, or idle when unrouted.
  wire [3:0] p0GrpIn = p0HiSel ? p0HiPadIn : {4{IDLE_IN}};
  wire [3:0] p3GrpIn = spiTgtSel ? p3PadIn[3:0] : {4{IDLE_IN}};
  wire [3:0] mstGrpIn = spiSwap ? p3GrpIn : p0GrpIn;
  wire [3:0] tgtGrpIn = spiSwap ? p0GrpIn : p3GrpIn;

  // Port 0 upper pins: GPIO or an SPI group.
  wire [7:0] p0HiS = {4'h0, {4{p0HiSel}}};
  wire [7:0] p0HiOut = pick(p0HiS, {4'h0, gpio0Out[7:4]},
                            {4'h0, p0GrpOut});
  wire [7:0] p0HiOeN = pick(p0HiS, {4'h0, gpio0OeN[7:4]},
                            {4'h0, p0GrpOeN});

  // I2C target pads, ordered {t1 sda, t1 scl, t0 sda, t0 scl}.
  wire [7:0] i2cS = {4'h0, {2{i2c1Sel}}, {2{i2c0Sel}}};
  wire [7:0] i2cOut = pick(i2cS, 8'h00, {4'h0, gpio0Out[7:4]});
  wire [7:0] i2cOeN = pick(i2cS, {4'h0, i2cTargetOeN},
                           {4'h0, gpio0OeN[7:4]});

  // USB power pads, ordered {d1 overcurrent, d1 enable, d0 oc, d0 en}.
  wire [7:0] usbS = {4'h0, {2{ds1Sel}}, {2{ds0Sel}}};
  wire [7:0] usbOut = pick(usbS,
                           {4'h0, 1'b0, downstreamPowerEnable[1],
                            1'b0, downstreamPowerEnable[0]},
                           {4'h0, gpio0Out[3:0]});
  wire [7:0] usbOeN = pick(usbS, 8'h0a, {4'h0, gpio0OeN[3:0]});

  // Port 2: bit 0 master select 1, bits 1-3 debugger, 4-7 modem lines.
  wire [7:0] p2S = {{2{modemBSel}}, {2{modemASel}},
                    {3{dbgSel}}, p20Sel};
  wire [7:0] p2PerOut = {4'h0, debuggerDataOut, debuggerClockOut,
                         1'b0, mstSel1N};
  wire [7:0] p2PerOeN = 8'hf2;
  wire [7:0] p2Out = pick(p2S, gpio2Out, p2PerOut);
  wire [7:0] p2OeN = pick(p2S, gpio2OeN, p2PerOeN);
  wire [7:0] p2PerIn = pick(p2S, {8{IDLE_IN}}, p2PadIn);

  // Port 3: low nibble SPI group, high nibble keyboard/mouse channels.
  wire [7:0] p3S = {{4{kbdSel}}, {4{spiTgtSel}}};
  wire [7:0] p3Out = pick(p3S, gpio3Out, {4'h0, p3GrpOut});
  wire [7:0] p3OeN = pick(p3S, gpio3OeN, {kbdMouseOeN, p3GrpOeN});

  // Port 1 bit 7: GPIO or master select 2.
  wire p17Out = p17Sel ? mstSel2N : gpio1Bit7Out;
  wire p17OeN = p17Sel ? 1'b0 : gpio1Bit7OeN;

  // Pad drive, released while blocked.
  assign p0HiPadOut = p0HiOut[3:0] & passOut[3:0];
  assign p0HiPadOeN = p0HiOeN[3:0] | blockOeN[3:0];
  assign i2cPadOut = i2cOut[3:0] & passOut[3:0];
  assign i2cPadOeN = i2cOeN[3:0] | blockOeN[3:0];
  assign usbPwrPadOut = usbOut[3:0] & passOut[3:0];
  assign usbPwrPadOeN = usbOeN[3:0] | blockOeN[3:0];
  assign p2PadOut = p2Out & passOut;
  assign p2PadOeN = p2OeN | blockOeN;
  assign p3PadOut = p3Out & passOut;
  assign p3PadOeN = p3OeN | blockOeN;
  assign p17PadOut = p17Out & !blocked;
  assign p17PadOeN = p17OeN | blocked;

  // Inputs back to GPIO: from wherever each bit is routed, else idle.
  wire [3:0] gpio0LoIn = {ds1Sel ? usbPwrPadIn[3:2] : {2{IDLE_IN}},
                          ds0Sel ? usbPwrPadIn[1:0] : {2{IDLE_IN}}};
  wire [1:0] gpio0B54 = i2c0Sel ? i2cPadIn[1:0] :
                        (p0HiSel ? {2{IDLE_IN}} : p0HiPadIn[1:0]);
  wire [1:0] gpio0B76 = i2c1Sel ? i2cPadIn[3:2] :
                        (p0HiSel ? {2{IDLE_IN}} : p0HiPadIn[3:2]);
  assign gpio0In = {gpio0B76, gpio0B54, gpio0LoIn};
  assign gpio1Bit7In = p17Sel ? IDLE_IN : p17PadIn;
  assign gpio2In = pick(p2S, p2PadIn, {8{IDLE_IN}});
  assign gpio3In = pick(p3S, p3PadIn, {8{IDLE_IN}});

  // Inputs to peripherals.
  assign debuggerDataIn = p2PerIn[1];
  assign modemClearToSend = p2PerIn[4];
  assign modemDataSetReady = p2PerIn[5];
  assign modemRing = p2PerIn[6];
  assign modemCarrier = p2PerIn[7];
  assign mstMiso = mstGrpIn[3];
  assign tgtSelN = tgtGrpIn[0];
  assign tgtClk = tgtGrpIn[1];
  assign tgtMosi = tgtGrpIn[2];
  assign kbdMouseIn = kbdSel ? p3PadIn[7:4] : {4{IDLE_IN}};
  assign i2cTargetIn = {i2c1Sel ? {2{IDLE_IN}} : i2cPadIn[3:2],
                        i2c0Sel ? {2{IDLE_IN}} : i2cPadIn[1:0]};
  assign downstreamOvercurrent = {ds1Sel ? IDLE_IN : usbPwrPadIn[3],
                                  ds0Sel ? IDLE_IN : usbPwrPadIn[1]};

  // USB resistors: upstream pull-up follows its controller unless off.
  wire [3:0] upOff = usbPull[PULL_UP_LSB +: 4];
  wire [3:0] downOff = usbPull[PULL_DN_LSB +: 4];
  assign upPullupEn = upPullupReq & ~upOff;
  assign downPulldownEn = ~downOff;

  // Latched configuration as seen by software; zero until loaded.
  assign pinFunctionSelectA = selA;
  assign pinFunctionSelectB = selB;
  assign pinFunctionSelectC = selC;
  assign usbResistorDisable = usbPull;
  assign loaderDone = loadDone;
  assign pinsBlocked = blocked;

endmodule // multifunction_pin_select_cfg

// File: sim/flash_info_model.sv
// Behavioural flash information page that answers the loader's byte reads.
`timescale 1ns/10ps
module flash_info_model (
  input wire logic mclk,
  input wire logic infoRead,
  input wire logic [pin_cfg_pkg::INFO_AW-1:0] infoAddr,
  output logic [7:0] infoData,
  output logic infoValid
);
  import pin_cfg_pkg::*;
  logic [7:0] mem [0:4];
  logic [7:0] lastByte;
  int slow;
  int cnt;

  initial begin
    infoValid = 1'b0;
    infoData = 8'h00;
    lastByte = 8'h00;
    slow = 0;
    cnt = 0;
  end

  // The data lines are not held after the pulse, so a loader that samples
  // late sees the inverse of the byte rather than a lucky match.
  always @(posedge mclk) begin
    if (cnt > 0) begin
      cnt = cnt - 1;
      if (cnt == 0) begin
        lastByte = mem[infoAddr];
        infoValid <= #1 1'b1;
        infoData <= #1 lastByte;
      end
    end else begin
      infoValid <= #1 1'b0;
      infoData <= #1 ~lastByte;
    end
    if (infoRead) begin
      cnt = slow + 1;
    end
  end
endmodule // flash_info_model

// File: sim/pin_select_chk.sv
// Concurrent checks on the loader link and the pin routing outputs.
`timescale 1ns/10ps
module pin_select_chk (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic infoRead,
  input wire logic [pin_cfg_pkg::INFO_AW-1:0] infoAddr,
  input wire logic [7:0] infoData,
  input wire logic infoValid,
  input wire logic loaderDone,
  input wire logic pinsBlocked,
  input wire logic [7:0] pinFunctionSelectA,
  input wire logic [7:0] pinFunctionSelectB,
  input wire logic [7:0] pinFunctionSelectC,
  input wire logic [7:0] usbResistorDisable,
  input wire logic [3:0] upPullupReq,
  input wire logic [3:0] upPullupEn,
  input wire logic [3:0] downPulldownEn,
  input wire logic [7:0] p2PadIn,
  input wire logic [7:0] p2PadOut,
  input wire logic debuggerDataIn,
  input wire logic debuggerClockOut,
  input wire logic debuggerDataOut,
  input wire logic modemClearToSend,
  input wire logic modemDataSetReady,
  input wire logic [3:0] i2cPadIn,
  input wire logic [3:0] i2cTargetIn
);
  import pin_cfg_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  chk_blocked_zero: assert property (pinsBlocked |->
    {pinFunctionSelectA, pinFunctionSelectB, pinFunctionSelectC,
     usbResistorDisable} == 32'h0) else $error("config not zero");
  chk_pullup_off: assert property (upPullupEn ==
    (upPullupReq & ~usbResistorDisable[3:0])) else $error("pull-up wrong");
  chk_pulldown_off: assert property (downPulldownEn ==
    ~usbResistorDisable[7:4]) else $error("pull-down wrong");
  chk_config_hold: assert property ($past(!pinsBlocked)
    && !pinsBlocked |-> $stable(pinFunctionSelectA) &&
    $stable(pinFunctionSelectB) && $stable(pinFunctionSelectC) &&
    $stable(usbResistorDisable)) else $error("config changed");
  chk_read_pulse: assert property (infoRead |=> !infoRead)
    else $error("read not a pulse");
  chk_next_read: assert property (infoValid && infoAddr < 10'h004 &&
    (infoAddr != FLAG_OFS || infoData == FLAG_VALID) |=> infoRead &&
    infoAddr == $past(infoAddr) + 10'h001) else $error("read order wrong");
  chk_bad_flag: assert property (infoValid && infoAddr == FLAG_OFS &&
    infoData != FLAG_VALID |-> ##[1:4] (loaderDone && pinsBlocked))
    else $error("bad flag not blocked");
  chk_load_commit: assert property (infoValid && infoAddr == 10'h004
    |-> ##[1:3] (loaderDone && !pinsBlocked)) else $error("no commit");
  chk_debug_route: assert property (!pinsBlocked &&
    pinFunctionSelectB[B_DBG] |-> debuggerDataIn == p2PadIn[1] &&
    p2PadOut[3:2] == {debuggerDataOut, debuggerClockOut})
    else $error("debug route wrong");
  chk_modem_route: assert property (!pinsBlocked &&
    pinFunctionSelectB[B_MODEM_A] |-> {modemDataSetReady, modemClearToSend}
    == p2PadIn[5:4]) else $error("modem route wrong");
  chk_i2c_forced: assert property (!pinsBlocked &&
    !pinFunctionSelectA[A_P0_HI] |-> i2cTargetIn == i2cPadIn)
    else $error("i2c not forced");

  cover property (infoValid && infoAddr == FLAG_OFS && infoData != FLAG_VALID);
  cover property (!pinsBlocked && pinFunctionSelectB[B_DBG]);
  cover property ($rose(loaderDone) && !pinsBlocked);
endmodule // pin_select_chk

bind multifunction_pin_select_cfg pin_select_chk u_chk (.*);

// File: sim/testbench.sv
// Self-checking bench: flash loads followed by pin routing checks.
`timescale 1ns/10ps
module testbench;
  import pin_cfg_pkg::*;
  logic mclk, resetn, infoRead, infoValid, loaderDone, pinsBlocked;
  logic [INFO_AW-1:0] infoAddr;
  logic [7:0] infoData, pinFunctionSelectA, pinFunctionSelectB;
  logic [7:0] pinFunctionSelectC, usbResistorDisable;
  logic [7:0] gpio0Out, gpio0OeN, gpio0In, gpio2Out, gpio2OeN, gpio2In;
  logic [7:0] gpio3Out, gpio3OeN, gpio3In, p2PadIn, p2PadOut, p2PadOeN;
  logic [7:0] p3PadIn, p3PadOut, p3PadOeN;
  logic gpio1Bit7Out, gpio1Bit7OeN, gpio1Bit7In, debuggerDataIn;
  logic debuggerClockOut, debuggerDataOut, modemClearToSend;
  logic modemDataSetReady, modemRing, modemCarrier;
  logic mstSel0N, mstSel1N, mstSel2N, mstClk, mstMosi, mstMiso;
  logic tgtSelN, tgtClk, tgtMosi, tgtMiso, tgtMisoOeN;
  logic p17PadIn, p17PadOut, p17PadOeN;
  logic [3:0] kbdMouseOeN, kbdMouseIn, i2cTargetOeN, i2cTargetIn;
  logic [3:0] p0HiPadIn, p0HiPadOut, p0HiPadOeN, i2cPadIn, i2cPadOut;
  logic [3:0] i2cPadOeN, usbPwrPadIn, usbPwrPadOut, usbPwrPadOeN;
  logic [3:0] upPullupReq, upPullupEn, downPulldownEn;
  logic [1:0] downstreamPowerEnable, downstreamOvercurrent;
  int failures;
  int tests_run;

  multifunction_pin_select_cfg u_dut (.*);
  flash_info_model u_flash (.mclk(mclk), .infoRead(infoRead),
    .infoAddr(infoAddr), .infoData(infoData), .infoValid(infoValid));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Every input follows one pattern so that routing slips show as mismatches.
  task automatic drive(input logic [7:0] p);
    {gpio0Out, gpio2Out, gpio3Out} = {p, ~p, p};
    {gpio0OeN, gpio2OeN, gpio3OeN} = {~p, p, ~p};
    {gpio1Bit7Out, gpio1Bit7OeN, debuggerClockOut, debuggerDataOut} = p[3:0];
    {mstSel0N, mstSel1N, mstSel2N, mstClk, mstMosi, tgtMiso} = p[7:2];
    {tgtMisoOeN, p17PadIn} = p[1:0];
    {kbdMouseOeN, i2cTargetOeN} = ~p;
    {p0HiPadIn, i2cPadIn} = {p[3:0], p[7:4]};
    p2PadIn = p;
    p3PadIn = ~p;
    {usbPwrPadIn, upPullupReq} = p;
    downstreamPowerEnable = p[1:0];
  endtask

  task automatic boot(input logic [7:0] fl, a, b, c, u, input int sl);
    int n;
    u_flash.mem[0] = fl;
    u_flash.mem[1] = a;
    u_flash.mem[2] = b;
    u_flash.mem[3] = c;
    u_flash.mem[4] = u;
    u_flash.slow = sl;
    resetn = 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    check({pinsBlocked, loaderDone}, 8'h02);
    check(pinFunctionSelectB | pinFunctionSelectC, 8'h00);
    check(downPulldownEn, 4'hf);
    check(upPullupEn, upPullupReq);
    check(p2PadOeN & p3PadOeN, 8'hff);
    resetn = 1'b1;
    n = 0;
    while (loaderDone !== 1'b1 && n < 200) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (loaderDone !== 1'b1) begin
      failures++;
      results();
    end
    @(posedge mclk);
    #1;
  endtask

  initial begin
    resetn = 1'b0;
    failures = 0;
    tests_run = 0;
    drive(8'h00);
    // Loaded: debug, modem, SPI target, keyboard and I2C-to-GPIO all
    // selected with the SPI groups swapped; reserved bits of byte 3 set.
    boot(FLAG_VALID, 8'h84, 8'hff, 8'hfb, 8'h5a, 0);
    check(pinsBlocked, 1'b0);
    check(pinFunctionSelectA, 8'h84);
    check(pinFunctionSelectB, 8'hff);
    check(pinFunctionSelectC, 8'h0b);
    check(usbResistorDisable, 8'h5a);
    for (int i = 0; i < 2; i++) begin
      drive(i == 0 ? 8'h96 : 8'h69);
      #1;
      check(upPullupEn, upPullupReq & 4'h5);
      check(downPulldownEn, 4'ha);
      check(debuggerDataIn, p2PadIn[1]);
      check(p2PadOut[3:2], {debuggerDataOut, debuggerClockOut});
      check({modemCarrier, modemRing, modemDataSetReady, modemClearToSend},
        p2PadIn[7:4]);
      check({tgtMosi, tgtClk, tgtSelN}, p0HiPadIn[2:0]);
      check(p3PadOut[2:0], {mstMosi, mstClk, mstSel0N});
      check(mstMiso, p3PadIn[3]);
      check(kbdMouseIn, p3PadIn[7:4]);
      check(gpio0In[7:4], i2cPadIn);
      check(gpio0In[3:0], usbPwrPadIn);
      check(p0HiPadOut, {tgtMiso, 3'b000});
      check(p0HiPadOeN, {tgtMisoOeN, 3'b111});
      check(p3PadOeN, {kbdMouseOeN, 4'h8});
      check(p2PadOeN, 8'hf2);
      check(p2PadOut[0], mstSel1N);
      check({p17PadOut, p17PadOeN, gpio1Bit7In}, {mstSel2N, 2'b01});
      check(i2cPadOut, gpio0Out[7:4]);
      check(i2cPadOeN, gpio0OeN[7:4]);
      check(usbPwrPadOut, gpio0Out[3:0]);
      check(usbPwrPadOeN, gpio0OeN[3:0]);
      @(posedge mclk);
      #1;
    end
    // I2C selects programmed but overridden by a clear port 0 select.
    boot(FLAG_VALID, 8'h00, 8'hc0, 8'h00, 8'h00, 2);
    drive(8'ha5);
    #1;
    check(pinFunctionSelectB, 8'hc0);
    check(i2cTargetIn, i2cPadIn);
    check(gpio0In[7:4], p0HiPadIn);
    check(gpio2In[7:1], p2PadIn[7:1]);
    check(gpio3In, p3PadIn);
    check(downstreamOvercurrent, {usbPwrPadIn[3], usbPwrPadIn[1]});
    check({usbPwrPadOut[2], usbPwrPadOut[0]}, downstreamPowerEnable);
    check({p17PadOut, p17PadOeN, gpio1Bit7In},
      {gpio1Bit7Out, gpio1Bit7OeN, p17PadIn});
    check(downPulldownEn, 4'hf);
    check(upPullupEn, upPullupReq);
    // SPI groups in their home places: master on port 0, target on port 3.
    boot(FLAG_VALID, 8'h04, 8'h10, 8'h00, 8'h00, 1);
    drive(8'h3c);
    #1;
    check(p0HiPadOut[2:0], {mstMosi, mstClk, mstSel0N});
    check(p0HiPadOeN, 4'h8);
    check(mstMiso, p0HiPadIn[3]);
    check({tgtMosi, tgtClk, tgtSelN}, p3PadIn[2:0]);
    check({p3PadOut[3], p3PadOeN[3]}, {tgtMiso, tgtMisoOeN});
    check(gpio3In, {p3PadIn[7:4], 4'hf});
    check(gpio0In[7:4], 4'hf);
    check(i2cTargetIn, i2cPadIn);
    check({i2cPadOut, i2cPadOeN}, {4'h0, i2cTargetOeN});
    // A wrong marker must leave the pins blocked and the settings clear.
    boot(8'h5b, 8'hff, 8'hff, 8'h0f, 8'hff, 1);
    check({pinsBlocked, loaderDone}, 8'h03);
    check(pinFunctionSelectA | pinFunctionSelectB, 8'h00);
    check(usbResistorDisable, 8'h00);
    check(downPulldownEn, 4'hf);
    check(p2PadOeN & p3PadOeN, 8'hff);
    check(p2PadOut | p3PadOut, 8'h00);
    check({p0HiPadOeN, i2cPadOeN}, 8'hff);
    check({p0HiPadOut, i2cPadOut}, 8'h00);
    check({usbPwrPadOeN, usbPwrPadOut}, 8'hf0);
    check({p17PadOeN, p17PadOut}, 8'h02);
    results();
  end
endmodule // testbench
